// >>> cvsd_pcm_converter.sv
// Purpose: Delta-modulation voice codec with PCM buffers, delta FIFOs and law translator.
// Assumes: Bus strobes last one cycle and are synchronous to sys_clk_in.
// Notes:   Read data appears one cycle after the read strobe.
`timescale 1ns/100ps

module cvsd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset
  input  wire logic                sys_clk_in,
  input  wire logic                rstn_in,
  // Filling side
  input  wire logic                in_valid_in,
  input  wire logic [WIDTH-1:0]    in_data_in,
  output logic                     in_ready_out,
  // Draining side
  output logic                     out_valid_out,
  output logic [WIDTH-1:0]         out_data_out,
  input  wire logic                out_ready_in,
  // Fill level
  output logic [$clog2(DEPTH):0]   count_out
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = AW + 1;
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0]               rd;
    logic [AW-1:0]               wr;
    logic [AW:0]                 cnt;
    logic                        ready;
    logic                        valid;
  } fifo_t;
  fifo_t st;
  fifo_t next_st;
  logic  push;
  logic  pop;

  assign push = in_valid_in && st.ready;
  assign pop = out_ready_in && st.valid;

  always_comb
  begin
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wr] = in_data_in;
      next_st.wr = st.wr + 1'b1;
    end
    if (pop)
      next_st.rd = st.rd + 1'b1;
    next_st.cnt = st.cnt + CW'(push) - CW'(pop);
    next_st.ready = next_st.cnt != CW'(DEPTH);
    next_st.valid = next_st.cnt != '0;
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
    begin
      st <= '0;
      st.ready <= 1'b1;
    end
    else
      st <= next_st;
  end

  assign in_ready_out = st.ready;
  assign out_valid_out = st.valid;
  assign out_data_out = st.mem[st.rd];
  assign count_out = st.cnt;
endmodule

module cvsd_pcm_converter #(
  parameter int SAMPLE_CYCLES = cvsd_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  // Peripheral bus
  input  wire logic [23:0] bus_addr_in,
  input  wire logic        bus_wr_in,
  input  wire logic        bus_rd_in,
  input  wire logic [15:0] bus_wdata_in,
  output logic [15:0]      bus_rdata_out,
  // Emulator
  input  wire logic        freeze_in,
  // Requests
  output logic             irq_out,
  output logic [3:0]       dma_req_out
);
  localparam int TICK_CYCLES = SAMPLE_CYCLES / cvsd_pkg::UPSAMPLE;

  typedef struct packed {
    logic [15:0] ctl;
    logic [4:0]  stat;
    logic [15:0] pin;
    logic        pin_new;
    logic [15:0] pout;
    logic [15:0] lin_out;
    logic [7:0]  log_out;
    logic [15:0] rdata;
    logic        irq;
    logic [3:0]  dma;
    logic [15:0] scnt;
    logic [15:0] tcnt;
    logic [2:0]  phase;
    logic [15:0] cur;
    logic [15:0] prev;
    logic [15:0] e_est;
    logic [15:0] e_step;
    logic [3:0]  e_hist;
    logic [15:0] e_word;
    logic [3:0]  e_n;
    logic [15:0] d_est;
    logic [15:0] d_step;
    logic [3:0]  d_hist;
    logic [15:0] d_word;
    logic [3:0]  d_idx;
    logic [18:0] d_sum;
    logic [3:0]  icnt_q;
    logic [3:0]  ocnt_q;
  } state_t;
  state_t st;
  state_t nx;

  // ----------------------------------------------------------------
  // Conversion functions
  // ----------------------------------------------------------------
  function automatic logic [15:0] expand(input logic alaw, input logic [7:0] c);
    logic [7:0]  u;
    logic [16:0] t;
    logic [15:0] m;
    u = alaw ? (c ^ cvsd_pkg::A_XOR_NEG) : ~c;
    if (alaw)
    begin
      t = {9'h0, u[3:0], 4'h8};
      if (u[6:4] != 3'h0)
        t = (t + 17'h100) << (u[6:4] - 3'h1);
      m = t[15:0];
      return u[7] ? m : -m;
    end
    t = ({10'h0, u[3:0], 3'h0} + 17'(cvsd_pkg::MU_BIAS)) << u[6:4];
    m = t[15:0] - cvsd_pkg::MU_BIAS;
    return u[7] ? -m : m;
  endfunction

  function automatic logic [7:0] compress(input logic alaw, input logic [15:0] x);
    logic [15:0] p;
    logic [2:0]  e;
    logic [3:0]  m;
    e = 3'h0;
    if (alaw)
    begin
      p = (x[15] ? ~x : x) >> 3;
      for (int i = 5; i < 12; i++)
        if (p[i])
          e = 3'(i - 4);
      m = (e == 3'h0) ? p[4:1] : 4'(p >> e);
      return {1'b0, e, m} ^ (x[15] ? cvsd_pkg::A_XOR_NEG : cvsd_pkg::A_XOR_POS);
    end
    p = x[15] ? -(x & cvsd_pkg::MU_KEEP) : (x & cvsd_pkg::MU_KEEP);
    p = ((p > cvsd_pkg::MU_CLIP) ? cvsd_pkg::MU_CLIP : p) + cvsd_pkg::MU_BIAS;
    for (int i = 8; i < 15; i++)
      if (p[i])
        e = 3'(i - 7);
    m = 4'(p >> (4'(e) + 4'h3));
    return ~{x[15], e, m};
  endfunction

  function automatic logic [15:0] to_lin(input logic [1:0] f, input logic [15:0] s);
    if (f == cvsd_pkg::FMT_MU || f == cvsd_pkg::FMT_A)
      return expand(f == cvsd_pkg::FMT_A, s[7:0]);
    return s;
  endfunction

  function automatic logic [15:0] from_lin(input logic [1:0] f, input logic [15:0] s);
    if (f == cvsd_pkg::FMT_MU || f == cvsd_pkg::FMT_A)
      return {8'h0, compress(f == cvsd_pkg::FMT_A, s)};
    return s;
  endfunction

  function automatic logic [15:0] adapt(input logic [15:0] step, input logic run);
    if (run)
      return (step > cvsd_pkg::STEP_MAX - cvsd_pkg::STEP_INC) ? cvsd_pkg::STEP_MAX
                                                              : step + cvsd_pkg::STEP_INC;
    return (step - (step >> 4) < cvsd_pkg::STEP_MIN) ? cvsd_pkg::STEP_MIN : step - (step >> 4);
  endfunction

  function automatic logic [15:0] integ(input logic [15:0] est, input logic [15:0] step,
                                        input logic up);
    logic [16:0] s;
    s = up ? {est[15], est} + {1'b0, step} : {est[15], est} - {1'b0, step};
    if (s[16] != s[15])
      return s[16] ? cvsd_pkg::SAT_NEG : cvsd_pkg::SAT_POS;
    return s[15:0];
  endfunction

  // ----------------------------------------------------------------
  // Delta FIFOs
  // ----------------------------------------------------------------
  logic        wr_en;
  logic        rd_stat;
  logic        active;
  logic        sample_end;
  logic        tick;
  logic        ififo_ready;
  logic        ififo_valid;
  logic [15:0] ififo_data;
  logic [3:0]  ififo_cnt;
  logic        ofifo_ready;
  logic        ofifo_valid;
  logic [15:0] ofifo_data;
  logic [3:0]  ofifo_cnt;
  logic        d_load;
  logic [15:0] d_w;
  logic        d_bit;
  logic        e_push;
  logic        e_bit;
  logic [16:0] diff;
  logic [20:0] prod;
  logic [20:0] interp;
  logic [3:0]  e_hist_n;
  logic [15:0] e_step_n;
  logic [3:0]  d_hist_n;
  logic [15:0] d_step_n;
  logic [15:0] d_est_n;
  logic [18:0] d_sum_n;
  logic [4:0]  set_v;
  logic [4:0]  clr_v;

  assign wr_en = bus_wr_in && st.ctl[cvsd_pkg::CTL_EN];
  assign rd_stat = bus_rd_in && bus_addr_in == cvsd_pkg::ADDR_STAT;

  cvsd_fifo #(.WIDTH(16), .DEPTH(cvsd_pkg::FIFO_DEPTH)) in_fifo (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (wr_en && bus_addr_in == cvsd_pkg::ADDR_DELTA_IN),
    .in_data_in    (bus_wdata_in),
    .in_ready_out  (ififo_ready),
    .out_valid_out (ififo_valid),
    .out_data_out  (ififo_data),
    .out_ready_in  (d_load),
    .count_out     (ififo_cnt)
  );

  cvsd_fifo #(.WIDTH(16), .DEPTH(cvsd_pkg::FIFO_DEPTH)) out_fifo (
    .sys_clk_in    (sys_clk_in),
    .rstn_in       (rstn_in),
    .in_valid_in   (e_push),
    .in_data_in    ({e_bit, st.e_word[15:1]}),
    .in_ready_out  (ofifo_ready),
    .out_valid_out (ofifo_valid),
    .out_data_out  (ofifo_data),
    .out_ready_in  (st.ctl[cvsd_pkg::CTL_EN] && bus_rd_in
                    && bus_addr_in == cvsd_pkg::ADDR_DELTA_OUT),
    .count_out     (ofifo_cnt)
  );

  // ----------------------------------------------------------------
  // Codec timebase and datapath
  // ----------------------------------------------------------------
  assign active = st.ctl[cvsd_pkg::CTL_EN] && st.ctl[cvsd_pkg::CTL_CLK];
  assign sample_end = active && st.scnt == 16'(SAMPLE_CYCLES - 1);
  assign tick = sample_end || (active && st.tcnt == 16'(TICK_CYCLES - 1) && st.phase != 3'h7);
  assign diff = {st.cur[15], st.cur} - {st.prev[15], st.prev};
  assign prod = $signed({{4{diff[16]}}, diff}) * $signed({18'h0, st.phase});
  assign interp = {{5{st.prev[15]}}, st.prev} + 21'($signed(prod) >>> 3);
  assign e_bit = $signed(interp[15:0]) >= $signed(st.e_est);
  assign e_hist_n = {st.e_hist[2:0], e_bit};
  assign e_step_n = adapt(st.e_step, &e_hist_n || ~|e_hist_n);
  assign e_push = tick && st.e_n == 4'hf && !freeze_in;
  assign d_load = tick && st.d_idx == 4'h0 && !freeze_in;
  assign d_w = d_load ? (ififo_valid ? ififo_data : cvsd_pkg::CHECKER) : st.d_word;
  assign d_bit = d_w[st.d_idx];
  assign d_hist_n = {st.d_hist[2:0], d_bit};
  assign d_step_n = adapt(st.d_step, &d_hist_n || ~|d_hist_n);
  assign d_est_n = integ(st.d_est, d_step_n, d_bit);
  assign d_sum_n = st.d_sum + {{3{d_est_n[15]}}, d_est_n};
  assign set_v = {e_push && !ofifo_ready,
                  d_load && !ififo_valid,
                  sample_end,
                  ofifo_cnt >= cvsd_pkg::NEAR_FULL_LEVEL && st.ocnt_q < cvsd_pkg::NEAR_FULL_LEVEL,
                  ififo_cnt == cvsd_pkg::NEAR_LEVEL && st.icnt_q != cvsd_pkg::NEAR_LEVEL};
  assign clr_v = !rd_stat ? 5'h00 : (freeze_in ? 5'h03 : 5'h1f);

  always_comb
  begin
    nx = st;
    nx.dma = 4'h0;
    nx.rdata = 16'h0;
    nx.icnt_q = ififo_cnt;
    nx.ocnt_q = ofifo_cnt;
    if (!active)
    begin
      nx.scnt = 16'h0;
      nx.tcnt = 16'h0;
      nx.phase = 3'h0;
    end
    else
    begin
      nx.scnt = sample_end ? 16'h0 : st.scnt + 16'h1;
      nx.tcnt = tick ? 16'h0 : st.tcnt + 16'h1;
      nx.phase = tick ? st.phase + 3'h1 : st.phase;
    end
    if (sample_end)
    begin
      nx.prev = st.cur;
      nx.cur = 16'($signed(to_lin(st.ctl[10:9], st.pin)) >>> st.ctl[13:12]);
      nx.pin_new = 1'b0;
      nx.dma[1] = st.ctl[cvsd_pkg::CTL_SI_DMA];
    end
    if (tick)
    begin
      nx.e_hist = e_hist_n;
      nx.e_step = e_step_n;
      nx.e_est = integ(st.e_est, e_step_n, e_bit);
      nx.e_word = {e_bit, st.e_word[15:1]};
      nx.e_n = st.e_n + 4'h1;
      nx.d_word = d_w;
      nx.d_idx = st.d_idx + 4'h1;
      nx.d_hist = d_hist_n;
      nx.d_step = d_step_n;
      nx.d_est = d_est_n;
      nx.d_sum = sample_end ? 19'h0 : d_sum_n;
    end
    if (sample_end && !freeze_in)
    begin
      nx.pout = from_lin(st.ctl[10:9], d_sum_n[18:3]);
      nx.dma[0] = st.ctl[cvsd_pkg::CTL_SO_DMA];
    end
    nx.dma[2] = e_push && ofifo_ready && st.ctl[cvsd_pkg::CTL_DO_DMA];
    nx.dma[3] = d_load && ififo_valid && st.ctl[cvsd_pkg::CTL_DI_DMA];
    if (bus_wr_in && bus_addr_in == cvsd_pkg::ADDR_CTRL)
      nx.ctl = bus_wdata_in & cvsd_pkg::CTL_MASK;
    if (wr_en && bus_addr_in == cvsd_pkg::ADDR_PCM_IN)
    begin
      nx.pin = bus_wdata_in;
      nx.pin_new = 1'b1;
    end
    if (wr_en && bus_addr_in == cvsd_pkg::ADDR_COMP_IN)
      nx.lin_out = expand(st.ctl[cvsd_pkg::CTL_LAW], bus_wdata_in[7:0]);
    if (wr_en && bus_addr_in == cvsd_pkg::ADDR_LIN_IN)
      nx.log_out = compress(st.ctl[cvsd_pkg::CTL_LAW], bus_wdata_in);
    if (bus_rd_in)
    begin
      case (bus_addr_in)
        cvsd_pkg::ADDR_DELTA_OUT: nx.rdata = ofifo_data;
        cvsd_pkg::ADDR_PCM_OUT: nx.rdata = st.pout;
        cvsd_pkg::ADDR_COMP_OUT: nx.rdata = {8'h0, st.log_out};
        cvsd_pkg::ADDR_LIN_OUT: nx.rdata = st.lin_out;
        cvsd_pkg::ADDR_CTRL: nx.rdata = st.ctl;
        cvsd_pkg::ADDR_STAT: nx.rdata = st.ctl[cvsd_pkg::CTL_EN]
                                        ? {5'h0, ofifo_cnt[2:0], ififo_cnt[2:0], st.stat}
                                        : 16'h0000;
        default: nx.rdata = 16'h0;
      endcase
    end
    nx.stat = st.ctl[cvsd_pkg::CTL_EN] ? ((st.stat & ~clr_v) | set_v) : 5'h00;
    nx.irq = |(nx.stat & {{2{st.ctl[cvsd_pkg::CTL_EIRQ]}}, st.ctl[cvsd_pkg::CTL_SIRQ],
                          {2{st.ctl[cvsd_pkg::CTL_LIRQ]}}});
  end

  always_ff @(posedge sys_clk_in)
  begin
    if (!rstn_in)
      st <= '0;
    else
      st <= nx;
  end

  assign bus_rdata_out = st.rdata;
  assign irq_out = st.irq;
  assign dma_req_out = st.dma;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_status_off;
    !st.ctl[cvsd_pkg::CTL_EN] |=> st.stat == 5'h00;
  endproperty
  a_status_off: assert property (p_status_off) else $error("Status set while disabled.");

  property p_full_hold;
    (e_push && !ofifo_ready && !(bus_rd_in && bus_addr_in == cvsd_pkg::ADDR_DELTA_OUT))
      |=> ofifo_cnt == 4'h8 && st.stat[cvsd_pkg::ST_F];
  endproperty
  a_full_hold: assert property (p_full_hold) else $error("Full output FIFO changed.");

  property p_freeze_pop;
    freeze_in |=> ififo_cnt >= $past(ififo_cnt);
  endproperty
  a_freeze_pop: assert property (p_freeze_pop) else $error("Input FIFO popped in freeze.");

  property p_freeze_keep;
    (freeze_in && rd_stat && st.ctl[cvsd_pkg::CTL_EN] && nx.ctl[cvsd_pkg::CTL_EN])
      |=> (st.stat[4:2] & $past(st.stat[4:2])) == $past(st.stat[4:2]);
  endproperty
  a_freeze_keep: assert property (p_freeze_keep) else $error("Flag lost in freeze.");

  property p_near_clear;
    (rd_stat && set_v[1:0] == 2'h0) |=> st.stat[1:0] == 2'h0;
  endproperty
  a_near_clear: assert property (p_near_clear) else $error("Near flags kept on read.");

  property p_near_empty;
    (st.ctl[cvsd_pkg::CTL_EN] && nx.ctl[cvsd_pkg::CTL_EN] && ififo_cnt == 4'h3
      && st.icnt_q != 4'h3) |=> st.stat[cvsd_pkg::ST_NE];
  endproperty
  a_near_empty: assert property (p_near_empty) else $error("Nearly empty missed.");

  property p_checker;
    (d_load && !ififo_valid) |=> st.d_word == cvsd_pkg::CHECKER;
  endproperty
  a_checker: assert property (p_checker) else $error("Empty read not checkerboard.");

  property p_sample_rate;
    sample_end |=> !sample_end [*8];
  endproperty
  a_sample_rate: assert property (p_sample_rate) else $error("Sample period too short.");

  property p_word_rate;
    e_push |-> sample_end && st.e_n == 4'hf;
  endproperty
  a_word_rate: assert property (p_word_rate) else $error("Delta word off its slot.");

  property p_irq_src;
    irq_out |-> st.stat != 5'h00;
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("Interrupt without a flag.");

  c_push: cover property (e_push && ofifo_ready);
  c_empty_read: cover property (d_load && !ififo_valid);
  c_status_read: cover property (rd_stat && st.stat != 5'h00);
endmodule

// >>> cvsd_pkg.sv
// Purpose: Shared constants of the delta-modulation voice codec block.
// Assumes: 25 MHz system clock; 16-bit peripheral bus at the printed byte addresses.
// Notes:   Codec timing is derived from the system clock.

package cvsd_pkg;
  // ----------------------------------------------------------------
  // Register addresses
  // ----------------------------------------------------------------
  localparam logic [23:0] ADDR_DELTA_IN  = 24'hfffc20;
  localparam logic [23:0] ADDR_DELTA_OUT = 24'hfffc22;
  localparam logic [23:0] ADDR_PCM_IN    = 24'hfffc24;
  localparam logic [23:0] ADDR_PCM_OUT   = 24'hfffc26;
  localparam logic [23:0] ADDR_COMP_IN   = 24'hfffc28;
  localparam logic [23:0] ADDR_COMP_OUT  = 24'hfffc2a;
  localparam logic [23:0] ADDR_LIN_IN    = 24'hfffc2c;
  localparam logic [23:0] ADDR_LIN_OUT   = 24'hfffc2e;
  localparam logic [23:0] ADDR_CTRL      = 24'hfffc30;
  localparam logic [23:0] ADDR_STAT      = 24'hfffc32;
  // ----------------------------------------------------------------
  // Control and status fields
  // ----------------------------------------------------------------
  localparam int CTL_EN = 0;
  localparam int CTL_CLK = 1;
  localparam int CTL_SIRQ = 2;
  localparam int CTL_LIRQ = 3;
  localparam int CTL_EIRQ = 4;
  localparam int CTL_DO_DMA = 5;
  localparam int CTL_DI_DMA = 6;
  localparam int CTL_SO_DMA = 7;
  localparam int CTL_SI_DMA = 8;
  localparam int CTL_FMT = 9;
  localparam int CTL_LAW = 11;
  localparam int CTL_RES = 12;
  localparam logic [15:0] CTL_MASK = 16'h3fff;
  localparam logic [15:0] CTL_RESET = 16'h0000;
  localparam int ST_NE = 0;
  localparam int ST_NF = 1;
  localparam int ST_SMP = 2;
  localparam int ST_E = 3;
  localparam int ST_F = 4;
  localparam logic [1:0] FMT_MU = 2'h1;
  localparam logic [1:0] FMT_A = 2'h2;
  // ----------------------------------------------------------------
  // Timing, FIFO and codec constants
  // ----------------------------------------------------------------
  localparam int SYS_CLK_HZ = 25_000_000;
  localparam int SAMPLE_PERIOD_NS = 125_000;
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / 1000 * (SYS_CLK_HZ / 1_000_000);
  localparam int UPSAMPLE = 8;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] NEAR_LEVEL = 4'h3;
  localparam logic [3:0] NEAR_FULL_LEVEL = 4'h5;
  localparam logic [15:0] CHECKER = 16'haaaa;
  localparam logic [15:0] STEP_MIN = 16'h000a;
  localparam logic [15:0] STEP_MAX = 16'h0500;
  localparam logic [15:0] STEP_INC = 16'h000a;
  localparam logic [15:0] SAT_POS = 16'h7fff;
  localparam logic [15:0] SAT_NEG = 16'h8000;
  localparam logic [15:0] MU_BIAS = 16'h0084;
  localparam logic [15:0] MU_CLIP = 16'h7f7b;
  localparam logic [15:0] MU_KEEP = 16'hfffc;
  localparam logic [7:0] A_XOR_NEG = 8'h55;
  localparam logic [7:0] A_XOR_POS = 8'hd5;
endpackage

// >>> cvsd_bus_master.sv
// Purpose: Bus master model of the CPU and DMA side of the codec block.
// Assumes: Strobes start after a rising edge and last one cycle.
// Notes:   Read data is taken at the edge that ends the strobe.
`timescale 1ns/100ps
module cvsd_bus_master (
  // Clock
  input  wire logic        sys_clk_in,
  // Bus
  output logic [23:0]      bus_addr_out,
  output logic             bus_wr_out,
  output logic             bus_rd_out,
  output logic [15:0]      bus_wdata_out,
  input  wire logic [15:0] bus_rdata_in
);
  initial
  begin
    bus_addr_out = 24'h000000;
    bus_wr_out = 1'b0;
    bus_rd_out = 1'b0;
    bus_wdata_out = 16'h0000;
  end
  task automatic wr(input logic [23:0] a, input logic [15:0] d);
    @(posedge sys_clk_in);
    bus_addr_out <= a;
    bus_wdata_out <= d;
    bus_wr_out <= 1'b1;
    @(posedge sys_clk_in);
    bus_wr_out <= 1'b0;
    bus_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [23:0] a, output logic [15:0] d);
    @(posedge sys_clk_in);
    bus_addr_out <= a;
    bus_rd_out <= 1'b1;
    @(posedge sys_clk_in);
    bus_rd_out <= 1'b0;
    #1 d = bus_rdata_in;
  endtask
  // Drops enables that would share one trigger between interrupt and DMA.
  task automatic set_ctrl(input logic [15:0] d);
    logic [15:0] v;
    v = d;
    if (v[2]) v[8:7] = 2'h0;
    if (v[3]) v[6:5] = 2'h0;
    wr(cvsd_pkg::ADDR_CTRL, v);
  endtask
  // Pops the delta output only when the status shows a word waiting.
  task automatic pop_delta(output logic [15:0] d);
    logic [15:0] s;
    rd(cvsd_pkg::ADDR_STAT, s);
    d = 16'h0000;
    if (s[10:8] != 3'h0 || s[4]) rd(cvsd_pkg::ADDR_DELTA_OUT, d);
  endtask
endmodule

// >>> cvsd_pcm_converter_tb.sv
// Purpose: Self-checking bench of the codec block.
// Assumes: Sample period shortened to 64 cycles.
// Notes:   Reset check and register rows first, then codec, freeze and decode tests.
`timescale 1ns/100ps
module cvsd_pcm_converter_tb;
  localparam int SC = 64;
  typedef struct {logic [23:0] wa; logic [15:0] wd; logic [23:0] ra; logic [15:0] ex;} row_t;
  logic        sys_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        freeze_in = 1'b0;
  logic [23:0] bus_addr;
  logic        bus_wr;
  logic        bus_rd;
  logic [15:0] bus_wdata;
  logic [15:0] bus_rdata;
  logic        irq_out;
  logic [3:0]  dma_req_out;
  logic [15:0] v;
  int          num_errors = 0;
  int          n_checks = 0;
  int          n_dma [4];
  row_t        rows [10];
  cvsd_pcm_converter #(.SAMPLE_CYCLES(SC)) uut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in),
    .bus_addr_in(bus_addr), .bus_wr_in(bus_wr), .bus_rd_in(bus_rd), .bus_wdata_in(bus_wdata),
    .bus_rdata_out(bus_rdata), .freeze_in(freeze_in), .irq_out(irq_out),
    .dma_req_out(dma_req_out));
  cvsd_bus_master cpu (.sys_clk_in(sys_clk_in), .bus_addr_out(bus_addr), .bus_wr_out(bus_wr),
    .bus_rd_out(bus_rd), .bus_wdata_out(bus_wdata), .bus_rdata_in(bus_rdata));
  // The system clock also stands in for the codec clock.
  initial
  begin
    forever #20 sys_clk_in = ~sys_clk_in;
  end
  always @(posedge sys_clk_in)
  begin
    for (int i = 0; i < 4; i++)
      if (dma_req_out[i] === 1'b1) n_dma[i] <= n_dma[i] + 1;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic span(input int c);
    repeat (c) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic window(input int c);
    span(SC / 2);
    n_dma = '{default: 0};
    span(c);
  endtask
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    repeat (20000) @(posedge sys_clk_in);
    num_errors++;
    wrap_up();
  end
  // --------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------
  initial
  begin
    n_dma = '{default: 0};
    rows[0] = '{cvsd_pkg::ADDR_CTRL, 16'hff61, cvsd_pkg::ADDR_CTRL, 16'h3f61};
    rows[1] = '{24'hfffc34, 16'h1234, 24'hfffc34, 16'h0000};
    rows[2] = '{cvsd_pkg::ADDR_PCM_IN, 16'h1111, cvsd_pkg::ADDR_PCM_IN, 16'h0000};
    rows[3] = '{cvsd_pkg::ADDR_CTRL, 16'h0001, cvsd_pkg::ADDR_CTRL, 16'h0001};
    rows[4] = '{cvsd_pkg::ADDR_COMP_IN, 16'h00ff, cvsd_pkg::ADDR_LIN_OUT, 16'h0000};
    rows[5] = '{cvsd_pkg::ADDR_COMP_IN, 16'h0080, cvsd_pkg::ADDR_LIN_OUT, 16'h7d7c};
    rows[6] = '{cvsd_pkg::ADDR_COMP_IN, 16'h0000, cvsd_pkg::ADDR_LIN_OUT, 16'h8284};
    rows[7] = '{cvsd_pkg::ADDR_CTRL, 16'h0801, cvsd_pkg::ADDR_CTRL, 16'h0801};
    rows[8] = '{cvsd_pkg::ADDR_LIN_IN, 16'h7ffc, cvsd_pkg::ADDR_COMP_OUT, 16'h00aa};
    rows[9] = '{cvsd_pkg::ADDR_COMP_IN, 16'h00d5, cvsd_pkg::ADDR_LIN_OUT, 16'h0008};
    repeat (20) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    #1;
    check(16'({irq_out, dma_req_out}), 16'h0000);
    cpu.rd(cvsd_pkg::ADDR_CTRL, v);
    check(v, 16'h0000);
    cpu.rd(cvsd_pkg::ADDR_STAT, v);
    check(v, 16'h0000);
    $display("reset test done");
    foreach (rows[i])
    begin
      cpu.wr(rows[i].wa, rows[i].wd);
      cpu.rd(rows[i].ra, v);
      check(v, rows[i].ex);
    end
    $display("register table test done");
    cpu.wr(cvsd_pkg::ADDR_PCM_IN, 16'h1000);
    cpu.set_ctrl(16'h0133);
    window(8 * SC);
    check(16'(n_dma[1]), 16'd8);
    check(16'(n_dma[2]), 16'd4);
    span(11 * SC);
    check(16'(irq_out), 16'h0001);
    cpu.rd(cvsd_pkg::ADDR_STAT, v);
    check(v, 16'h001e);
    $display("encode fill test done");
    span(2 * SC + 3);
    @(posedge sys_clk_in) freeze_in <= 1'b1;
    cpu.rd(cvsd_pkg::ADDR_STAT, v);
    check(v, 16'h001c);
    cpu.wr(cvsd_pkg::ADDR_DELTA_IN, 16'h0ff0);
    cpu.wr(cvsd_pkg::ADDR_DELTA_IN, 16'h0ff0);
    for (int i = 0; i < 4; i++)
      cpu.pop_delta(v);
    cpu.rd(cvsd_pkg::ADDR_STAT, v);
    check(v, 16'h045c);
    for (int i = 0; i < 4; i++)
      cpu.pop_delta(v);
    span(4 * SC);
    cpu.rd(cvsd_pkg::ADDR_STAT, v);
    check(v, 16'h005c);
    @(posedge sys_clk_in) freeze_in <= 1'b0;
    span(2 * SC);
    window(4 * SC);
    check(16'(n_dma[2]), 16'd2);
    $display("freeze test done");
    cpu.set_ctrl(16'h0173);
    for (int i = 0; i < 4; i++)
      cpu.wr(cvsd_pkg::ADDR_DELTA_IN, 16'h0ff0);
    window(4 * SC);
    check(16'(n_dma[3]), 16'd2);
    cpu.rd(cvsd_pkg::ADDR_STAT, v);
    check(v & 16'h0001, 16'h0001);
    $display("decode test done");
    cpu.wr(cvsd_pkg::ADDR_CTRL, 16'h0000);
    cpu.rd(cvsd_pkg::ADDR_STAT, v);
    check(v, 16'h0000);
    check(16'(irq_out), 16'h0000);
    $display("disable test done");
    wrap_up();
  end
endmodule
